// ---- rtl/cmoh_message_handler.v ----
// message object handler: 32 objects, acceptance filter, transmit priority, axi4-lite registers
// assumes a protocol core that offers received frames as one-cycle pulses and
// reports transmit completion or failure with one-cycle pulses
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cmoh_defines.vh"
module cmoh_message_handler #(
    parameter NOBJ = 32
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire rx_valid_i,
    input wire [28:0] rx_id_i,
    input wire rx_xtd_i,
    input wire rx_rtr_i,
    input wire [3:0] rx_dlc_i,
    input wire [63:0] rx_data_i,
    input wire tx_ready_i,
    input wire tx_done_i,
    input wire tx_fail_i,
    output reg tx_req_o,
    output reg [28:0] tx_id_o,
    output reg tx_xtd_o,
    output reg tx_rtr_o,
    output reg [3:0] tx_dlc_o,
    output reg [63:0] tx_data_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // object storage
    reg [28:0] mid [0:NOBJ-1];
    reg [28:0] msk [0:NOBJ-1];
    reg [3:0] dlc [0:NOBJ-1];
    reg [63:0] mdat [0:NOBJ-1];
    reg [NOBJ-1:0] valid, txrq, new_data_flag, irq_pending, message_lost_flag;
    reg [NOBJ-1:0] rx_irq_enable, tx_irq_enable, remote_answer_enable, use_acceptance_mask, end_of_block, dir, xtd, mask_extended_select, mask_direction;

    // software side
    reg [31:0] ctrl, if_arb, if_msk, if_ctl, if_da, if_db;
    reg aw_full, w_full;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] rd_mux;
    reg rd_ok;
    reg wr_ok;

    // transmit state
    reg st;
    reg [4:0] tx_obj;
    reg [5:0] last_rx;

    // lowest set index, or the none code when no bit is set
    function [5:0] first;
        input [NOBJ-1:0] v;
        integer i;
        begin
            first = `CMOH_NONE;
            for (i = NOBJ - 1; i >= 0; i = i - 1) begin
                if (v[i])
                    first = i[5:0];
            end
        end
    endfunction

    // byte-lane merge under the write strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] s;
        reg [31:0] bm;
        begin
            bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
            merge = (old & ~bm) | (nw & bm);
        end
    endfunction

    // acceptance match per object
    // fifo members without end_of_block still holding unread data are skipped
    wire [NOBJ-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NOBJ; g = g + 1) begin : g_obj
            wire [28:0] idm = use_acceptance_mask[g] ? msk[g] : 29'h1FFFFFFF;
            wire [28:0] idc = xtd[g] ? idm : {idm[28:18], 18'h00000};
            assign hit[g] = valid[g] && (((rx_id_i ^ mid[g]) & idc) == 29'h00000000)
                && ((use_acceptance_mask[g] && !mask_extended_select[g]) || (rx_xtd_i == xtd[g]))
                && ((use_acceptance_mask[g] && !mask_direction[g]) || (rx_rtr_i == dir[g]))
                && !(new_data_flag[g] && !end_of_block[g] && !dir[g]);
        end
    endgenerate

    wire [5:0] rx_sel = first(hit);
    wire [4:0] rk = rx_sel[4:0];
    // frames are ignored while the init bit is set
    wire rx_go = rx_valid_i && !ctrl[`CMOH_CTRL_INIT] && !rx_sel[5];
    wire rx_rmt = rx_rtr_i && dir[rk];
    // remote frame on an answering object only raises its request
    wire rx_ans = rx_go && rx_rmt && remote_answer_enable[rk];
    wire rx_sto = rx_go && !rx_ans && !(rx_rmt && !use_acceptance_mask[rk]);

    // transmit pick, recomputed every cycle so any changed object is rescanned
    wire [5:0] tx_pick = first(valid & txrq);
    wire [4:0] tp = tx_pick[4:0];
    wire tx_start = (st == ST_IDLE) && !ctrl[`CMOH_CTRL_INIT] && tx_ready_i && !tx_pick[5];
    wire tx_ok = (st == ST_BUSY) && tx_done_i;

    // command decode
    // a command acts only when byte 0 of the word is written
    wire do_wr = aw_full && w_full && !s_axi_bvalid_o;
    wire [7:0] cnum = w_data[7:0];
    wire cmd_go = do_wr && (aw_addr == `CMOH_OFS_CMD) && w_strb[0]
        && (cnum != 8'h00) && (cnum <= NOBJ);
    wire [7:0] cm1 = cnum - 8'h01;
    wire [4:0] ci = cm1[4:0];
    wire cmd_wr = cmd_go && w_data[`CMOH_CMD_WR];
    wire cmd_rd = cmd_go && !w_data[`CMOH_CMD_WR];

    // axi4-lite write channel
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `CMOH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end else if (!aw_full) begin
                s_axi_awready_o <= 1'b1;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end else if (!w_full) begin
                s_axi_wready_o <= 1'b1;
            end
            if (do_wr) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? `CMOH_RESP_OKAY : `CMOH_RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // unmapped write addresses answer with a slave error
    always @* begin
        case (aw_addr)
            `CMOH_OFS_CTRL, `CMOH_OFS_CMD, `CMOH_OFS_IF_ARB, `CMOH_OFS_IF_MSK,
            `CMOH_OFS_IF_CTL, `CMOH_OFS_IF_DA, `CMOH_OFS_IF_DB, `CMOH_OFS_TXRQ,
            `CMOH_OFS_NEW_DATA_FLAG, `CMOH_OFS_IRQ_PENDING, `CMOH_OFS_OBJECT_VALID, `CMOH_OFS_STAT:
                wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // control and interface register set
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `CMOH_CTRL_RESET;
            if_arb <= 32'h00000000;
            if_msk <= 32'h00000000;
            if_ctl <= 32'h00000000;
            if_da <= 32'h00000000;
            if_db <= 32'h00000000;
        end else if (cmd_rd) begin
            if_arb <= {valid[ci], xtd[ci], dir[ci], mid[ci]};
            if_msk <= {mask_extended_select[ci], mask_direction[ci], 1'b0, msk[ci]};
            if_ctl <= {16'h0000, new_data_flag[ci], message_lost_flag[ci], irq_pending[ci], use_acceptance_mask[ci], tx_irq_enable[ci],
                rx_irq_enable[ci], remote_answer_enable[ci], txrq[ci], end_of_block[ci], 3'h0, dlc[ci]};
            if_da <= mdat[ci][31:0];
            if_db <= mdat[ci][63:32];
        end else if (do_wr) begin
            case (aw_addr)
                `CMOH_OFS_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & `CMOH_CTRL_RESET;
                `CMOH_OFS_IF_ARB: if_arb <= merge(if_arb, w_data, w_strb);
                `CMOH_OFS_IF_MSK: if_msk <= merge(if_msk, w_data, w_strb);
                `CMOH_OFS_IF_CTL: if_ctl <= merge(if_ctl, w_data, w_strb) & 32'h0000FF8F;
                `CMOH_OFS_IF_DA: if_da <= merge(if_da, w_data, w_strb);
                `CMOH_OFS_IF_DB: if_db <= merge(if_db, w_data, w_strb);
                default: ;
            endcase
        end
    end

    // object contents, no reset
    always @(posedge sys_clk_i) begin
        if (cmd_wr) begin
            mid[ci] <= if_arb[28:0];
            msk[ci] <= if_msk[28:0];
            dlc[ci] <= if_ctl[3:0];
            mdat[ci] <= {if_db, if_da};
        end
        if (rx_sto) begin
            mid[rk] <= rx_xtd_i ? rx_id_i : {rx_id_i[28:18], 18'h00000};
            dlc[rk] <= rx_dlc_i;
            if (!rx_rtr_i)
                mdat[rk] <= rx_data_i;
        end
    end

    // object flags; hardware sets come last so they win over software clears
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid <= {NOBJ{1'b0}};
            txrq <= {NOBJ{1'b0}};
            new_data_flag <= {NOBJ{1'b0}};
            irq_pending <= {NOBJ{1'b0}};
            message_lost_flag <= {NOBJ{1'b0}};
            rx_irq_enable <= {NOBJ{1'b0}};
            tx_irq_enable <= {NOBJ{1'b0}};
            remote_answer_enable <= {NOBJ{1'b0}};
            use_acceptance_mask <= {NOBJ{1'b0}};
            end_of_block <= {NOBJ{1'b0}};
            dir <= {NOBJ{1'b0}};
            xtd <= {NOBJ{1'b0}};
            mask_extended_select <= {NOBJ{1'b0}};
            mask_direction <= {NOBJ{1'b0}};
            last_rx <= `CMOH_NONE;
        end else begin
            if (tx_ok && !new_data_flag[tx_obj])
                txrq[tx_obj] <= 1'b0;
            if (tx_start)
                new_data_flag[tp] <= 1'b0;
            if (cmd_wr) begin
                valid[ci] <= if_arb[`CMOH_ARB_VAL];
                xtd[ci] <= if_arb[`CMOH_ARB_XTD];
                dir[ci] <= if_arb[`CMOH_ARB_DIR];
                mask_extended_select[ci] <= if_msk[`CMOH_MSK_MASK_EXTENDED_SELECT];
                mask_direction[ci] <= if_msk[`CMOH_MSK_MASK_DIRECTION];
                end_of_block[ci] <= if_ctl[`CMOH_CTL_EOB];
                txrq[ci] <= if_ctl[`CMOH_CTL_TXRQ];
                remote_answer_enable[ci] <= if_ctl[`CMOH_CTL_REMOTE_ANSWER_ENABLE];
                rx_irq_enable[ci] <= if_ctl[`CMOH_CTL_RX_IRQ_ENABLE];
                tx_irq_enable[ci] <= if_ctl[`CMOH_CTL_TX_IRQ_ENABLE];
                use_acceptance_mask[ci] <= if_ctl[`CMOH_CTL_USE_ACCEPTANCE_MASK];
                irq_pending[ci] <= if_ctl[`CMOH_CTL_IRQ_PENDING];
                message_lost_flag[ci] <= if_ctl[`CMOH_CTL_MESSAGE_LOST_FLAG];
                new_data_flag[ci] <= if_ctl[`CMOH_CTL_NEW_DATA_FLAG];
            end
            if (cmd_rd && w_data[`CMOH_CMD_CLR]) begin
                new_data_flag[ci] <= 1'b0;
                irq_pending[ci] <= 1'b0;
            end
            if (tx_ok && tx_irq_enable[tx_obj])
                irq_pending[tx_obj] <= 1'b1;
            if (rx_ans)
                txrq[rk] <= 1'b1;
            if (rx_sto) begin
                xtd[rk] <= rx_xtd_i;
                txrq[rk] <= 1'b0;
                new_data_flag[rk] <= 1'b1;
                message_lost_flag[rk] <= message_lost_flag[rk] | new_data_flag[rk];
                if (rx_irq_enable[rk])
                    irq_pending[rk] <= 1'b1;
            end
            if (rx_go)
                last_rx <= rx_sel;
        end
    end

    // transmit sequencing towards the core
    // done and fail both free the core; a failed object keeps its request
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= ST_IDLE;
            tx_obj <= 5'h00;
            tx_req_o <= 1'b0;
            tx_id_o <= 29'h00000000;
            tx_xtd_o <= 1'b0;
            tx_rtr_o <= 1'b0;
            tx_dlc_o <= 4'h0;
            tx_data_o <= 64'h0000000000000000;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (tx_start) begin
                        st <= ST_BUSY;
                        tx_obj <= tp;
                        tx_req_o <= 1'b1;
                        tx_id_o <= xtd[tp] ? mid[tp] : {mid[tp][28:18], 18'h00000};
                        tx_xtd_o <= xtd[tp];
                        tx_rtr_o <= !dir[tp];
                        tx_dlc_o <= dlc[tp];
                        tx_data_o <= mdat[tp];
                    end
                end
                ST_BUSY: begin
                    if (tx_done_i || tx_fail_i) begin
                        st <= ST_IDLE;
                        tx_req_o <= 1'b0;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    tx_req_o <= 1'b0;
                end
            endcase
        end
    end

    // read mux and summary registers
    // status word: busy, current tx object, last accepted object
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr_i)
            `CMOH_OFS_CTRL: rd_mux = ctrl;
            `CMOH_OFS_CMD: rd_mux = 32'h00000000;
            `CMOH_OFS_IF_ARB: rd_mux = if_arb;
            `CMOH_OFS_IF_MSK: rd_mux = if_msk;
            `CMOH_OFS_IF_CTL: rd_mux = if_ctl;
            `CMOH_OFS_IF_DA: rd_mux = if_da;
            `CMOH_OFS_IF_DB: rd_mux = if_db;
            `CMOH_OFS_TXRQ: rd_mux = txrq;
            `CMOH_OFS_NEW_DATA_FLAG: rd_mux = new_data_flag;
            `CMOH_OFS_IRQ_PENDING: rd_mux = irq_pending;
            `CMOH_OFS_OBJECT_VALID: rd_mux = valid;
            `CMOH_OFS_STAT: rd_mux = {18'h00000, st, tx_obj, 2'h0, last_rx};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // axi4-lite read channel
    // read data comes from the address seen at the accepting edge
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `CMOH_RESP_OKAY;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_mux;
                s_axi_rresp_o <= rd_ok ? `CMOH_RESP_OKAY : `CMOH_RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end else if (!s_axi_rvalid_o) begin
                s_axi_arready_o <= 1'b1;
            end
        end
    end
endmodule

// ---- rtl/cmoh_defines.vh ----
// constants of the message object handler: register offsets, field positions, reset values
// assumes inclusion by bare name from the handler module
// Summary of operation
// - remote frame on answering tx object sets request
// - standard objects compare only ID[28:18]
// - stored standard frames get zero ID[17:0]
// - tx_irq_enable sets irq_pending after transmission
// - store received length code and data bytes
// - masked id bits take received frame bits
// - rx_irq_enable sets irq_pending on stored frame
// - tx_request on receive object sends remote
// - remote store keeps data, no answer sent
// - fifo fills lowest first, end_of_block ends
// - per-object summary registers are read-only
// - lowest object number transmits first
// - acceptance scan ascending, first match wins
// - new accepted frame overwrites unread contents
// - changed object rescanned against last scan
// - move frames between ram and core
// - mask bits let one object take groups
// - after init, filter and store frames
// - store over unread data sets message_lost_flag
// - non-answering unmasked tx ignores remote frames
`ifndef CMOH_DEFINES_VH
`define CMOH_DEFINES_VH
`define CMOH_OFS_CTRL 8'h00
`define CMOH_OFS_CMD 8'h04
`define CMOH_OFS_IF_ARB 8'h08
`define CMOH_OFS_IF_MSK 8'h0C
`define CMOH_OFS_IF_CTL 8'h10
`define CMOH_OFS_IF_DA 8'h14
`define CMOH_OFS_IF_DB 8'h18
`define CMOH_OFS_TXRQ 8'h20
`define CMOH_OFS_NEW_DATA_FLAG 8'h24
`define CMOH_OFS_IRQ_PENDING 8'h28
`define CMOH_OFS_OBJECT_VALID 8'h2C
`define CMOH_OFS_STAT 8'h30
`define CMOH_CTRL_INIT 0
`define CMOH_CTRL_RESET 32'h00000001
`define CMOH_CMD_WR 8
`define CMOH_CMD_CLR 9
`define CMOH_ARB_DIR 29
`define CMOH_ARB_XTD 30
`define CMOH_ARB_VAL 31
`define CMOH_MSK_MASK_DIRECTION 30
`define CMOH_MSK_MASK_EXTENDED_SELECT 31
`define CMOH_CTL_EOB 7
`define CMOH_CTL_TXRQ 8
`define CMOH_CTL_REMOTE_ANSWER_ENABLE 9
`define CMOH_CTL_RX_IRQ_ENABLE 10
`define CMOH_CTL_TX_IRQ_ENABLE 11
`define CMOH_CTL_USE_ACCEPTANCE_MASK 12
`define CMOH_CTL_IRQ_PENDING 13
`define CMOH_CTL_MESSAGE_LOST_FLAG 14
`define CMOH_CTL_NEW_DATA_FLAG 15
`define CMOH_RESP_OKAY 2'h0
`define CMOH_RESP_SLVERR 2'h2
`define CMOH_NONE 6'h20
`endif

// ---- test/cmoh_chk.sv ----
// assertion checker on the message handler ports
// bound to every handler instance, sees its ports only
`timescale 1ns/1ps
module cmoh_chk (
    input wire sys_clk_i,
    input wire rst_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire tx_ready_i,
    input wire tx_done_i,
    input wire tx_fail_i,
    input wire tx_req_o,
    input wire [28:0] tx_id_o,
    input wire [63:0] tx_data_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read not answered");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
    a_tx_fields_hold: assert property (tx_req_o && !tx_done_i && !tx_fail_i
        |=> tx_req_o && $stable(tx_id_o) && $stable(tx_data_o)) else $error("tx frame moved");
    a_tx_end: assert property (tx_req_o && (tx_done_i || tx_fail_i)
        |=> !tx_req_o) else $error("tx request not released");
    a_tx_needs_ready: assert property ($rose(tx_req_o) |-> $past(tx_ready_i))
        else $error("tx loaded while core busy");
    a_tx_retry: assert property (tx_req_o && tx_fail_i && tx_ready_i
        |=> !tx_req_o ##[1:4] tx_req_o) else $error("failed frame not resent");
    c_tx_fail: cover property (tx_req_o && tx_fail_i);
    c_tx_done: cover property (tx_req_o && tx_done_i);
    c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule
bind cmoh_message_handler cmoh_chk u_cmoh_chk (.*);

// ---- test/cmoh_core_model.sv ----
// partner model of the protocol core: frame source and transmit completion
// frames are sent by tasks called from the testbench
`timescale 1ns/1ps
module cmoh_core_model (
    input wire sys_clk_i,
    input wire tx_req_i,
    output reg rx_valid_o,
    output reg [28:0] rx_id_o,
    output reg rx_xtd_o,
    output reg rx_rtr_o,
    output reg [3:0] rx_dlc_o,
    output reg [63:0] rx_data_o,
    output reg tx_ready_o,
    output reg tx_done_o,
    output reg tx_fail_o
);
    int cnt = 0;
    bit fail_once = 0;
    initial begin
        {rx_valid_o, rx_id_o, rx_xtd_o, rx_rtr_o, rx_dlc_o, rx_data_o} = 0;
        {tx_ready_o, tx_done_o, tx_fail_o} = 3'h4;
    end
    // bus time of a frame, then success or one lost arbitration
    always @(posedge sys_clk_i) begin
        tx_done_o <= 1'b0;
        tx_fail_o <= 1'b0;
        if (tx_req_i && !tx_done_o && !tx_fail_o) begin
            cnt <= cnt + 1;
            if (cnt == 3) begin
                cnt <= 0;
                tx_fail_o <= fail_once;
                tx_done_o <= !fail_once;
                fail_once <= 1'b0;
            end
        end
    end
    task send(input [28:0] id, input rtr, input [3:0] dlc, input [63:0] d);
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b1;
        {rx_id_o, rx_xtd_o, rx_rtr_o, rx_dlc_o, rx_data_o} <= {id, 1'b0, rtr, dlc, d};
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        // fields no longer valid: show the inverse
        {rx_id_o, rx_xtd_o, rx_rtr_o, rx_dlc_o, rx_data_o} <= ~{id, 1'b0, rtr, dlc, d};
    endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench: registers, receive, fifo, transmit priority, remote frames
// drives the handler over axi4-lite and the core side through the partner model
`timescale 1ns/1ps
`include "cmoh_defines.vh"
module tb_top;
    logic sys_clk_i = 0, rst_i = 1, txp = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, v;
    logic [3:0] s_axi_wstrb_i = 4'hF, rx_dlc_i, tx_dlc_o;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic rx_valid_i, rx_xtd_i, rx_rtr_i, tx_ready_i, tx_done_i, tx_fail_i;
    logic tx_req_o, tx_xtd_o, tx_rtr_o;
    logic [28:0] rx_id_i, tx_id_o;
    logic [63:0] rx_data_i, tx_data_o;
    logic [42:0] q[$];
    int n_errors = 0, compares = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    cmoh_message_handler u_cmoh_message_handler (.*);
    cmoh_core_model u_cmoh_core_model (.sys_clk_i(sys_clk_i), .tx_req_i(tx_req_o),
        .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i), .rx_xtd_o(rx_xtd_i), .rx_rtr_o(rx_rtr_i),
        .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i),
        .tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i));
    always @(posedge sys_clk_i) begin
        if (tx_req_o && !txp) q.push_back({tx_xtd_o, tx_dlc_o, tx_data_o[7:0], tx_rtr_o, tx_id_o});
        txp <= tx_req_o;
    end
    task stop_test();
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input [63:0] exp, input [63:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task hung(input int i);
        if (i == 60) begin
            chk("wait", 0, 1);
            stop_test();
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        int i;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o && s_axi_bready_i) break;
            if (s_axi_bvalid_o) s_axi_bready_i <= 1'b1;
        end
        hung(i);
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask
    task rd(input [7:0] a);
        int i;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o && s_axi_rready_i) break;
            if (s_axi_rvalid_o) s_axi_rready_i <= 1'b1;
        end
        hung(i);
        v = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask
    task rc(input [7:0] a, input [31:0] e, input string s);
        rd(a);
        chk(s, e, v);
    endtask
    task obj(input [7:0] n, input [31:0] arb, msk, ctl, da);
        wr(`CMOH_OFS_IF_ARB, arb);
        wr(`CMOH_OFS_IF_MSK, msk);
        wr(`CMOH_OFS_IF_CTL, ctl);
        wr(`CMOH_OFS_IF_DA, da);
        wr(`CMOH_OFS_IF_DB, 32'h0);
        wr(`CMOH_OFS_CMD, {23'h0, 1'b1, n});
    endtask
    task waitq(input int n);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge sys_clk_i);
            if (q.size() >= n && !tx_req_o) break;
        end
        hung(i);
    endtask
    task t_regs();
        rc(`CMOH_OFS_CTRL, `CMOH_CTRL_RESET, "ctrl");
        wr(`CMOH_OFS_TXRQ, 32'hFFFFFFFF);
        chk("wresp_ok", `CMOH_RESP_OKAY, resp);
        rc(`CMOH_OFS_TXRQ, 32'h0, "txrq");
        rc(`CMOH_OFS_OBJECT_VALID, 32'h0, "object_valid");
        rd(8'h3C);
        chk("unmapped", `CMOH_RESP_SLVERR, resp);
        wr(8'h3C, 32'h0);
        chk("wresp_err", `CMOH_RESP_SLVERR, resp);
        wr(`CMOH_OFS_CTRL, 32'h0);
    endtask
    task t_rx();
        obj(8'h01, 32'h848C0000, 32'h0, 32'h00000480, 32'h0);
        u_cmoh_core_model.send(29'h048FFFFF, 1'b0, 4'h8, 64'h0123456789ABCDEF);
        rc(`CMOH_OFS_NEW_DATA_FLAG, 32'h1, "new_data_flag");
        rc(`CMOH_OFS_IRQ_PENDING, 32'h1, "irq_pending");
        u_cmoh_core_model.send(29'h048C0001, 1'b0, 4'h8, 64'h1122334455667788);
        wr(`CMOH_OFS_CMD, 32'h00000201);
        rc(`CMOH_OFS_IF_ARB, 32'h848C0000, "arb");
        rd(`CMOH_OFS_IF_CTL);
        chk("ctl", 32'h00004088, v & 32'h0000408F);
        rc(`CMOH_OFS_IF_DA, 32'h55667788, "da");
        rc(`CMOH_OFS_IF_DB, 32'h11223344, "db");
        rc(`CMOH_OFS_NEW_DATA_FLAG, 32'h0, "new_data_flag");
    endtask
    task t_fifo();
        obj(8'h02, 32'h88000000, 32'hDFF00000, 32'h00001000, 32'h0);
        obj(8'h03, 32'h88000000, 32'hDFF00000, 32'h00001080, 32'h0);
        u_cmoh_core_model.send(29'h080C0000, 1'b0, 4'h1, 64'h0);
        u_cmoh_core_model.send(29'h08040000, 1'b0, 4'h1, 64'h0);
        rc(`CMOH_OFS_NEW_DATA_FLAG, 32'h6, "fifo");
        rc(`CMOH_OFS_STAT, 32'h2, "stat");
        wr(`CMOH_OFS_CMD, 32'h00000202);
        rc(`CMOH_OFS_IF_ARB, 32'h880C0000, "arb2");
        wr(`CMOH_OFS_CMD, 32'h00000203);
        rc(`CMOH_OFS_IF_ARB, 32'h88040000, "arb3");
    endtask
    task t_tx();
        wr(`CMOH_OFS_CTRL, 32'h1);
        obj(8'h04, 32'hE0000444, 32'h0, 32'h00000982, 32'h44);
        obj(8'h05, 32'hE0000555, 32'h0, 32'h00000182, 32'h55);
        u_cmoh_core_model.fail_once <= 1'b1;
        wr(`CMOH_OFS_CTRL, 32'h0);
        waitq(3);
        chk("tx1", {1'b1, 4'h2, 8'h44, 30'h00000444}, q[0]);
        chk("tx2", {1'b1, 4'h2, 8'h44, 30'h00000444}, q[1]);
        chk("tx3", {1'b1, 4'h2, 8'h55, 30'h00000555}, q[2]);
        rc(`CMOH_OFS_TXRQ, 32'h0, "txrq");
        rc(`CMOH_OFS_IRQ_PENDING, 32'h8, "txirq");
    endtask
    task t_remote();
        obj(8'h07, 32'hA2200000, 32'h0, 32'h00000081, 32'h0);
        u_cmoh_core_model.send(29'h02200000, 1'b1, 4'h1, 64'h0);
        obj(8'h08, 32'hA2640000, 32'hDFFFFFFF, 32'h00001080, 32'h99);
        u_cmoh_core_model.send(29'h02640000, 1'b1, 4'h3, 64'h0);
        wr(`CMOH_OFS_CMD, 32'h00000008);
        rc(`CMOH_OFS_IF_DA, 32'h99, "rmtdata");
        rd(`CMOH_OFS_IF_CTL);
        chk("rmtdlc", 32'h3, v & 32'hF);
        obj(8'h06, 32'hA1980000, 32'h0, 32'h00000281, 32'h5A);
        u_cmoh_core_model.send(29'h01980000, 1'b1, 4'h1, 64'h0);
        obj(8'h09, 32'h81DC0000, 32'h0, 32'h00000181, 32'h0);
        waitq(5);
        chk("count", 5, q.size());
        chk("answer", {1'b0, 4'h1, 8'h5A, 30'h01980000}, q[3]);
        chk("remote", {1'b0, 4'h1, 8'h00, 30'h21DC0000}, q[4]);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        t_regs();
        t_rx();
        t_fifo();
        t_tx();
        t_remote();
        stop_test();
    end
endmodule
